// [mro_output_stage.sv]
// Metering result output stage: distortion, sample bank, ready pin, pulses.
// Assumes the DSP drives rms, sample and power inputs synchronous to clk_sys
// and a serial port engine drives the register access port.
`timescale 1ns/1ns
`include "mro_defines.svh"
`default_nettype none

// ==========================================================================
// Energy-to-frequency converter
module mro_pulse_conv
	import mro_pkg::*;
#(
	parameter mro_acc_t THRESH = `MRO_PULSE_THRESH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic [2:0] include_bits,
	input wire logic [2:0] type_sel,
	input wire logic [4:0][2:0][23:0] phase_power,
	input wire logic pin_suppress,
	output logic pulse_n
);
	mro_acc_t acc_q, acc_d;
	logic pulse_q, pulse_d;
	mro_acc_t sum;
	mro_acc_t next_acc;

	always_comb begin
		sum = '0;
		for (int p = 0; p < 3; p++) begin
			if (include_bits[p] && type_sel <= `MRO_SEL_FUND_REACTIVE) begin
				sum = sum + {{8{phase_power[type_sel][p][23]}},
					phase_power[type_sel][p]};
			end
		end
		next_acc = acc_q + sum;
		acc_d = acc_q;
		pulse_d = pulse_q;
		if (tick) begin
			pulse_d = 1'b0;
			acc_d = next_acc;
			if ($signed(next_acc) >= $signed(THRESH)) begin
				acc_d = next_acc - THRESH;
				pulse_d = 1'b1;
			end else if ($signed(next_acc) <= -$signed(THRESH)) begin
				acc_d = next_acc + THRESH;
				pulse_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= '0;
			pulse_q <= 1'b0;
			pulse_n <= 1'b1;
		end else begin
			acc_q <= acc_d;
			pulse_q <= pulse_d;
			pulse_n <= !(pulse_d && !pin_suppress);
		end
	end
endmodule

// ==========================================================================
// Top level
module mro_output_stage
	import mro_pkg::*;
#(
	parameter int UPDATE_CYCLES = `MRO_UPDATE_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [5:0][23:0] rms_total,
	input wire logic [5:0][23:0] rms_fund,
	input wire logic [11:0][23:0] wave_in,
	input wire logic [4:0][2:0][23:0] phase_power,
	input wire logic crossing_in,
	input wire logic capture_port_en,
	input wire logic [3:0] capture_sel,
	output logic [31:0] capture_data,
	output logic irq_n,
	output logic crossing_ready_pin,
	output logic pulse_out_1_n,
	output logic pulse_out_2_n,
	output logic pulse_out_3_n
);
	localparam int DELAY_CYC = `MRO_READY_DELAY_CYC;
	localparam int LOW_CYC = `MRO_READY_LOW_CYC;

	// ======================================================================
	// Update divider
	logic [15:0] div_q, div_d;
	logic tick;

	assign tick = (div_q == 16'(UPDATE_CYCLES - 1));

	always_comb begin
		div_d = tick ? 16'h0 : div_q + 16'h1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= 16'h0;
		end else begin
			div_q <= div_d;
		end
	end

	// ======================================================================
	// Distortion engine
	// A bit-serial square root search trades cycles for area: six channels
	// take under two hundred cycles, far inside one update period.
	mro_thd_e thd_st_q, thd_st_d;
	logic [2:0] ch_q, ch_d;
	logic [4:0] bit_q, bit_d;
	logic [22:0] res_q, res_d;
	logic [23:0] fnd_q, fnd_d;
	logic [47:0] diff_q, diff_d;
	logic zero_q, zero_d;
	logic [5:0][23:0] thd_res_q, thd_res_d;
	logic [22:0] trial;
	logic [46:0] prod;
	logic [93:0] prod_sq;
	logic [93:0] target;

	always_comb begin
		thd_st_d = thd_st_q;
		ch_d = ch_q;
		bit_d = bit_q;
		res_d = res_q;
		fnd_d = fnd_q;
		diff_d = diff_q;
		zero_d = zero_q;
		thd_res_d = thd_res_q;
		trial = res_q | (23'h1 << bit_q);
		prod = 47'(trial * fnd_q);
		prod_sq = 94'(prod * prod);
		target = 94'({diff_q, {`MRO_THD_SQ_FRAC{1'b0}}});
		unique case (thd_st_q)
			THD_IDLE: begin
				if (tick) begin
					thd_st_d = THD_LOAD;
					ch_d = 3'h0;
				end
			end
			THD_LOAD: begin
				fnd_d = rms_fund[ch_q];
				zero_d = !(rms_total[ch_q] > rms_fund[ch_q]);
				diff_d = zero_d ? 48'h0 :
					48'(rms_total[ch_q] * rms_total[ch_q]) -
					48'(rms_fund[ch_q] * rms_fund[ch_q]);
				res_d = 23'h0;
				bit_d = `MRO_THD_TOP;
				thd_st_d = THD_RUN;
			end
			THD_RUN: begin
				if (!zero_q && prod_sq <= target) begin
					res_d = trial;
				end
				if (bit_q == 5'h0 || zero_q) begin
					thd_res_d[ch_q] = zero_q ? 24'h0 : {1'b0, res_d};
					ch_d = ch_q + 3'h1;
					thd_st_d = (ch_q == 3'(`MRO_THD_COUNT - 1)) ?
						THD_IDLE : THD_LOAD;
				end else begin
					bit_d = bit_q - 5'h1;
				end
			end
			default: thd_st_d = THD_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			thd_st_q <= THD_IDLE;
			ch_q <= 3'h0;
			bit_q <= 5'h0;
			res_q <= 23'h0;
			fnd_q <= 24'h0;
			diff_q <= 48'h0;
			zero_q <= 1'b0;
			thd_res_q <= '0;
		end else begin
			thd_st_q <= thd_st_d;
			ch_q <= ch_d;
			bit_q <= bit_d;
			res_q <= res_d;
			fnd_q <= fnd_d;
			diff_q <= diff_d;
			zero_q <= zero_d;
			thd_res_q <= thd_res_d;
		end
	end

	// ======================================================================
	// Registers and sample bank
	logic [20:0][23:0] bank_q, bank_d;
	logic [5:0][23:0] thd_q, thd_d;
	logic [31:0] status_q, status_d;
	logic [31:0] mask_q, mask_d;
	logic [15:0] comp_q, comp_d;
	logic [15:0] cfmode_q, cfmode_d;
	logic [15:0] config_q, config_d;
	logic [31:0] rdata_d;
	logic [31:0] cap_d;
	logic [15:0] off_thd;
	logic [15:0] off_wave;
	logic [4:0] cap_idx;

	function automatic logic [31:0] mro_fmt28(input logic [23:0] v);
		// Sign extend to 28, zero pad to 32.
		mro_fmt28 = {`MRO_PAD4, {4{v[23]}}, v};
	endfunction

	always_comb begin
		bank_d = bank_q;
		thd_d = thd_q;
		status_d = status_q;
		mask_d = mask_q;
		comp_d = comp_q;
		cfmode_d = cfmode_q;
		config_d = config_q;
		rdata_d = reg_rdata;
		off_thd = reg_addr - `MRO_ADDR_THD_BASE;
		off_wave = reg_addr - `MRO_ADDR_WAVE_BASE;
		if (reg_wr) begin
			unique case (reg_addr)
				`MRO_ADDR_STATUS: status_d = status_q & ~reg_wdata;
				`MRO_ADDR_MASK: mask_d = reg_wdata;
				`MRO_ADDR_COMPENSATION_MODE_CONTROL: comp_d = reg_wdata[15:0];
				`MRO_ADDR_CFMODE: cfmode_d = reg_wdata[15:0];
				`MRO_ADDR_CONFIG: config_d = reg_wdata[15:0];
				default: ;
			endcase
		end
		if (tick) begin
			bank_d[`MRO_WAVE_COUNT-1:0] = wave_in;
			for (int p = 0; p < 3; p++) begin
				bank_d[`MRO_BANK_APPARENT + p] = phase_power[`MRO_SEL_APPARENT][p];
				bank_d[`MRO_BANK_ACTIVE + p] = phase_power[`MRO_SEL_ACTIVE][p];
				bank_d[`MRO_BANK_REACTIVE + p] = phase_power[`MRO_SEL_REACTIVE][p];
			end
			thd_d = thd_res_q;
			// Set wins over a same-cycle clear.
			status_d[`MRO_BIT_READY] = 1'b1;
		end
		if (reg_rd) begin
			// Every read leaves as one 32-bit word.
			rdata_d = 32'h0;
			if (reg_addr >= `MRO_ADDR_THD_BASE &&
					reg_addr <= `MRO_ADDR_THD_LAST) begin
				rdata_d = {`MRO_PAD8, thd_q[off_thd[2:0]]};
			end else if (reg_addr >= `MRO_ADDR_WAVE_BASE &&
					reg_addr <= `MRO_ADDR_WAVE_LAST) begin
				rdata_d = mro_fmt28(bank_q[off_wave[4:0]]);
			end else begin
				unique case (reg_addr)
					`MRO_ADDR_STATUS: rdata_d = status_q;
					`MRO_ADDR_MASK: rdata_d = mask_q;
					`MRO_ADDR_COMPENSATION_MODE_CONTROL: rdata_d = {16'h0, comp_q};
					`MRO_ADDR_CFMODE: rdata_d = {16'h0, cfmode_q};
					`MRO_ADDR_CONFIG: rdata_d = {16'h0, config_q};
					default: rdata_d = 32'h0;
				endcase
			end
		end
		if (capture_sel <= 4'(`MRO_CAP_VOLT_LAST)) begin
			cap_idx = 5'(capture_sel);
		end else if (capture_sel < 4'(`MRO_CAP_REACTIVE)) begin
			cap_idx = 5'(capture_sel) + 5'(`MRO_BANK_ACTIVE - `MRO_CAP_ACTIVE);
		end else if (capture_sel < 4'(`MRO_CAP_APPARENT)) begin
			cap_idx = 5'(capture_sel) +
				5'(`MRO_BANK_REACTIVE - `MRO_CAP_REACTIVE);
		end else begin
			cap_idx = 5'(capture_sel) -
				5'(`MRO_CAP_APPARENT - `MRO_BANK_APPARENT);
		end
		cap_d = capture_port_en ? mro_fmt28(bank_q[cap_idx]) : 32'h0;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bank_q <= '0;
			thd_q <= '0;
			status_q <= `MRO_STATUS_RST;
			mask_q <= `MRO_MASK_RST;
			// Inclusion bits and selectors at defaults.
			comp_q <= `MRO_COMPENSATION_MODE_CONTROL_RST;
			cfmode_q <= `MRO_CFMODE_RST;
			config_q <= `MRO_CONFIG_RST;
			reg_rdata <= 32'h0;
			capture_data <= 32'h0;
			irq_n <= 1'b1;
		end else begin
			bank_q <= bank_d;
			thd_q <= thd_d;
			status_q <= status_d;
			mask_q <= mask_d;
			comp_q <= comp_d;
			cfmode_q <= cfmode_d;
			config_q <= config_d;
			reg_rdata <= rdata_d;
			capture_data <= cap_d;
			irq_n <= !(status_q[`MRO_BIT_READY] && mask_q[`MRO_BIT_READY]);
		end
	end

	// ======================================================================
	// Ready pin
	// The host is free to start its burst read on the rising edge here.
	mro_rdy_e rdy_st_q, rdy_st_d;
	logic [10:0] rdy_cnt_q, rdy_cnt_d;
	logic pin_d;

	always_comb begin
		rdy_st_d = rdy_st_q;
		rdy_cnt_d = rdy_cnt_q + 11'h1;
		unique case (rdy_st_q)
			RDY_IDLE: rdy_cnt_d = 11'h0;
			RDY_DELAY: begin
				// Low about 70 ns after flag.
				if (rdy_cnt_q == 11'(DELAY_CYC - 1)) begin
					rdy_st_d = RDY_LOW;
					rdy_cnt_d = 11'h0;
				end
			end
			RDY_LOW: begin
				if (rdy_cnt_q == 11'(LOW_CYC - 1)) begin
					rdy_st_d = RDY_IDLE;
					rdy_cnt_d = 11'h0;
				end
			end
			default: rdy_st_d = RDY_IDLE;
		endcase
		if (tick) begin
			rdy_st_d = RDY_DELAY;
			rdy_cnt_d = 11'h0;
		end
		// Ready function when select is 00.
		if (config_q[`MRO_PIN_SEL_LSB +: 2] == `MRO_PIN_SEL_READY) begin
			pin_d = (rdy_st_d != RDY_LOW);
		end else begin
			pin_d = crossing_in;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdy_st_q <= RDY_IDLE;
			rdy_cnt_q <= 11'h0;
			crossing_ready_pin <= 1'b1;
		end else begin
			rdy_st_q <= rdy_st_d;
			rdy_cnt_q <= rdy_cnt_d;
			crossing_ready_pin <= pin_d;
		end
	end

	// ======================================================================
	// Pulse converters
	// Fields at bits 2:0, 5:3, 8:6.
	mro_pulse_conv u_conv1 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.tick(tick),
		.include_bits(comp_q[`MRO_FIELD1_LSB +: 3]),
		.type_sel(cfmode_q[`MRO_FIELD1_LSB +: 3]),
		.phase_power(phase_power),
		.pin_suppress(1'b0),
		.pulse_n(pulse_out_1_n)
	);

	mro_pulse_conv u_conv2 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.tick(tick),
		.include_bits(comp_q[`MRO_FIELD2_LSB +: 3]),
		.type_sel(cfmode_q[`MRO_FIELD2_LSB +: 3]),
		.phase_power(phase_power),
		.pin_suppress(1'b0),
		.pulse_n(pulse_out_2_n)
	);

	// Third output yields to capture port enable.
	mro_pulse_conv u_conv3 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.tick(tick),
		.include_bits(comp_q[`MRO_FIELD3_LSB +: 3]),
		.type_sel(cfmode_q[`MRO_FIELD3_LSB +: 3]),
		.phase_power(phase_power),
		.pin_suppress(capture_port_en),
		.pulse_n(pulse_out_3_n)
	);
endmodule

`default_nettype wire

// [mro_defines.svh]
// Constants of the metering result output stage: offsets, resets, timing.
// Assumes inclusion by every file that needs them; holds definitions only.
`ifndef MRO_DEFINES_SVH
`define MRO_DEFINES_SVH

// ==========================================================================
// Register offsets
`define MRO_ADDR_STATUS 16'he502
`define MRO_ADDR_MASK 16'he50a
`define MRO_ADDR_THD_BASE 16'he521
`define MRO_ADDR_THD_LAST 16'he526
`define MRO_ADDR_WAVE_BASE 16'he580
`define MRO_ADDR_WAVE_LAST 16'he594
`define MRO_ADDR_COMPENSATION_MODE_CONTROL 16'he60e
`define MRO_ADDR_CFMODE 16'he610
`define MRO_ADDR_CONFIG 16'he618

// ==========================================================================
// Reset values and field positions
`define MRO_STATUS_RST 32'h0000_0000
`define MRO_MASK_RST 32'h0000_0000
`define MRO_COMPENSATION_MODE_CONTROL_RST 16'h01ff
`define MRO_CFMODE_RST 16'h0088
`define MRO_CONFIG_RST 16'h0000
`define MRO_BIT_READY 17
`define MRO_PIN_SEL_LSB 0
`define MRO_PIN_SEL_READY 2'h0
`define MRO_FIELD1_LSB 0
`define MRO_FIELD2_LSB 3
`define MRO_FIELD3_LSB 6

// ==========================================================================
// Power type codes
`define MRO_SEL_ACTIVE 3'h0
`define MRO_SEL_REACTIVE 3'h1
`define MRO_SEL_APPARENT 3'h2
`define MRO_SEL_FUND_ACTIVE 3'h3
`define MRO_SEL_FUND_REACTIVE 3'h4

// ==========================================================================
// Sample bank layout
`define MRO_WAVE_COUNT 12
`define MRO_BANK_COUNT 21
`define MRO_BANK_APPARENT 12
`define MRO_BANK_ACTIVE 15
`define MRO_BANK_REACTIVE 18
`define MRO_CAP_VOLT_LAST 6
`define MRO_CAP_ACTIVE 7
`define MRO_CAP_REACTIVE 10
`define MRO_CAP_APPARENT 13
`define MRO_THD_COUNT 6
`define MRO_THD_TOP 5'h16
`define MRO_THD_SQ_FRAC 42
`define MRO_PAD8 8'h00
`define MRO_PAD4 4'h0

// ==========================================================================
// Timing
`define MRO_CLK_MHZ 125
`define MRO_UPDATE_US 125
`define MRO_READY_DELAY_NS 70
`define MRO_READY_LOW_US 10
`define MRO_UPDATE_CYC (`MRO_UPDATE_US * `MRO_CLK_MHZ)
`define MRO_READY_DELAY_CYC ((`MRO_READY_DELAY_NS * `MRO_CLK_MHZ + 999) / 1000)
`define MRO_READY_LOW_CYC (`MRO_READY_LOW_US * `MRO_CLK_MHZ)
`define MRO_PULSE_THRESH 32'h0100_0000

`endif

// [mro_pkg.sv]
// Types shared by the metering result output stage.
// Assumes nothing of its surroundings.
package mro_pkg;
	typedef enum logic [1:0] {THD_IDLE, THD_LOAD, THD_RUN} mro_thd_e;
	typedef enum logic [1:0] {RDY_IDLE, RDY_DELAY, RDY_LOW} mro_rdy_e;
	typedef logic [23:0] mro_word_t;
	typedef logic [31:0] mro_acc_t;
endpackage

// [mro_output_stage_chk.sv]
// Checker for the result output stage: ready pin, interrupt, read padding.
// Assumes a bind to mro_output_stage; it sees only that module's ports.
`timescale 1ns/1ns
`include "mro_defines.svh"
`default_nettype none
// ============================================================
// Port checker
module mro_output_stage_chk (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic crossing_in,
	input wire logic capture_port_en,
	input wire logic [31:0] capture_data,
	input wire logic irq_n,
	input wire logic crossing_ready_pin,
	input wire logic pulse_out_3_n
);
	logic [1:0] sel_q, sel_d;
	logic msk_q, msk_d;
	logic [15:0] low_q, low_d;
	// Images of the pin select and mask bit, taken from the write strobes.
	always_comb begin
		sel_d = sel_q;
		msk_d = msk_q;
		low_d = crossing_ready_pin ? 16'h0 : low_q + 16'h1;
		if (reg_wr && reg_addr == `MRO_ADDR_CONFIG)
			sel_d = reg_wdata[1:0];
		if (reg_wr && reg_addr == `MRO_ADDR_MASK)
			msk_d = reg_wdata[17];
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= 2'h0;
			msk_q <= 1'b0;
			low_q <= 16'h0;
		end else begin
			sel_q <= sel_d;
			msk_q <= msk_d;
			low_q <= low_d;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// A mask set well before the fall rules out a fall caused by the write.
	sequence s_irq_fall;
		$past(msk_q, 3) && sel_q == 2'h0 && $fell(irq_n);
	endsequence
	sequence s_pin_fall;
		##8 $fell(crossing_ready_pin);
	endsequence
	property p_rdy_start;
		s_irq_fall |-> s_pin_fall;
	endproperty
	a_rdy_start: assert property (p_rdy_start)
		else $error("ready pin did not fall after flag");
	property p_rdy_len;
		sel_q == 2'h0 && $rose(crossing_ready_pin)
			|-> low_q == 16'(`MRO_READY_LOW_CYC);
	endproperty
	a_rdy_len: assert property (p_rdy_len)
		else $error("ready pulse length wrong");
	property p_irq_mask;
		$fell(irq_n) |-> msk_q;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt without mask");
	property p_mask_off;
		!msk_q && !$past(msk_q) && !$past(msk_q, 2) |-> irq_n;
	endproperty
	a_mask_off: assert property (p_mask_off)
		else $error("interrupt while masked");
	property p_irq_clear;
		reg_wr && reg_addr == `MRO_ADDR_STATUS && reg_wdata[17] |-> ##[1:3] irq_n;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt stuck after clear");
	property p_thd_pad;
		reg_rd && reg_addr inside {[16'he521:16'he526]}
			|=> reg_rdata[31:24] == 8'h00;
	endproperty
	a_thd_pad: assert property (p_thd_pad)
		else $error("distortion word top byte not zero");
	property p_bank_pad;
		reg_rd && reg_addr inside {[16'he580:16'he594]} |=> reg_rdata[31:28]
			== 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}};
	endproperty
	a_bank_pad: assert property (p_bank_pad)
		else $error("sample word not sign extended");
	property p_unmapped;
		reg_rd && reg_addr == 16'he700 |=> reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_cap_off;
		!capture_port_en && !$past(capture_port_en) |-> capture_data == 32'h0;
	endproperty
	a_cap_off: assert property (p_cap_off)
		else $error("capture data while disabled");
	property p_pulse3_off;
		capture_port_en && $past(capture_port_en) |-> pulse_out_3_n;
	endproperty
	a_pulse3_off: assert property (p_pulse3_off)
		else $error("third pulse output not suppressed");
	property p_pin_cross;
		sel_q != 2'h0 && $past(sel_q) != 2'h0
			|-> crossing_ready_pin == $past(crossing_in);
	endproperty
	a_pin_cross: assert property (p_pin_cross)
		else $error("pin does not follow crossing");
endmodule
`default_nettype wire

// [mro_host_model.sv]
// Host model: reads and writes registers of the output stage.
// Assumes the testbench calls one task at a time.
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Host
module mro_host_model (
	input wire logic clk_sys,
	input wire logic [31:0] reg_rdata,
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [31:0] reg_wdata
);
	initial begin
		reg_addr = 16'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
	end
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// The word is taken one edge after the strobe, once it has settled.
	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// Testbench of the output stage with a host model on its register port.
// Assumes the design, package, checker and host model are compiled first.
`timescale 1ns/1ns
`include "mro_defines.svh"
`default_nettype none
// ============================================================
// Testbench
module tb;
	localparam int UPD = 1300;
	logic clk_sys, arst_n, reg_wr, reg_rd, crossing_in, capture_port_en;
	logic irq_n, crossing_ready_pin, p1, p2, p3, lo1, lo2, lo3;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, capture_data, d;
	logic [3:0] capture_sel;
	logic [5:0][23:0] rms_total, rms_fund;
	logic [11:0][23:0] wave_in;
	logic [4:0][2:0][23:0] phase_power, pp;
	int fails, tests_run;
	mro_output_stage #(.UPDATE_CYCLES(UPD)) i_mro_output_stage (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .rms_total(rms_total), .rms_fund(rms_fund),
		.wave_in(wave_in), .phase_power(phase_power),
		.crossing_in(crossing_in), .capture_port_en(capture_port_en),
		.capture_sel(capture_sel), .capture_data(capture_data),
		.irq_n(irq_n), .crossing_ready_pin(crossing_ready_pin),
		.pulse_out_1_n(p1), .pulse_out_2_n(p2), .pulse_out_3_n(p3));
	mro_host_model i_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));
	task automatic chk(input string n, input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [31:0] f28(input logic [23:0] v);
		return {4'h0, {4{v[23]}}, v};
	endfunction
	task automatic until_pin(input logic v);
		int n;
		n = 0;
		while (crossing_ready_pin !== v) begin
			@(posedge clk_sys);
			#1 n++;
			if (n > 2 * UPD) begin
				chk("ready wait", 32'h1, 32'h0);
				wrap_up;
			end
		end
	endtask
	task automatic t_config;
		i_host.wr(`MRO_ADDR_CONFIG, 32'h1);
		crossing_in <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk("crossing low", 32'(crossing_ready_pin), 32'h0);
		@(posedge clk_sys);
		crossing_in <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk("crossing high", 32'(crossing_ready_pin), 32'h1);
		i_host.wr(`MRO_ADDR_CONFIG, 32'h0);
		$display("t_config done");
	endtask
	task automatic t_reset;
		i_host.rd(`MRO_ADDR_COMPENSATION_MODE_CONTROL, d);
		chk("compensation_mode_control", d, 32'h0000_01ff);
		i_host.rd(`MRO_ADDR_CFMODE, d);
		chk("cfmode", d, 32'h0000_0088);
		i_host.rd(16'he700, d);
		chk("unmapped", d, 32'h0);
		chk("irq idle", 32'(irq_n), 32'h1);
		$display("t_reset done");
	endtask
	task automatic t_ready;
		int n;
		logic [23:0] e;
		until_pin(1'b0);
		until_pin(1'b1);
		i_host.wr(`MRO_ADDR_STATUS, 32'h0002_0000);
		i_host.wr(`MRO_ADDR_MASK, 32'h0002_0000);
		until_pin(1'b0);
		n = 0;
		while (crossing_ready_pin === 1'b0 && n < 2000) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk("low cycles", 32'(n), 32'(`MRO_READY_LOW_CYC));
		if (n >= 2000)
			wrap_up;
		chk("irq", 32'(irq_n), 32'h0);
		i_host.rd(`MRO_ADDR_STATUS, d);
		chk("ready flag", 32'(d[17]), 32'h1);
		// The rising edge starts the burst of sample reads.
		for (int i = 0; i < 21; i++) begin
			i_host.rd(`MRO_ADDR_WAVE_BASE + 16'(i), d);
			e = i < 12 ? wave_in[i] :
				phase_power[i < 15 ? 2 : i < 18 ? 0 : 1][(i - 12) % 3];
			chk("bank", d, f28(e));
		end
		for (int i = 0; i < 6; i++) begin
			i_host.rd(`MRO_ADDR_THD_BASE + 16'(i), d);
			e = i == 0 ? 24'h18_0000 : i == 1 ? 24'h7f_ffff : 24'h0;
			chk("thd", d, {8'h00, e});
		end
		i_host.wr(`MRO_ADDR_STATUS, 32'h0002_0000);
		i_host.rd(`MRO_ADDR_STATUS, d);
		chk("flag clear", 32'(d[17]), 32'h0);
		chk("irq clear", 32'(irq_n), 32'h1);
		i_host.wr(`MRO_ADDR_MASK, 32'h0);
		// Wait for a fresh flag to be set while the mask bit is clear.
		until_pin(1'b1);
		until_pin(1'b0);
		chk("irq masked", 32'(irq_n), 32'h1);
		$display("t_ready done");
	endtask
	task automatic watch;
		lo1 = 1'b0;
		lo2 = 1'b0;
		lo3 = 1'b0;
		repeat (UPD + 10) @(posedge clk_sys);
		repeat (5 * UPD) begin
			@(posedge clk_sys);
			#1 lo1 |= !p1;
			lo2 |= !p2;
			lo3 |= !p3;
		end
	endtask
	task automatic t_pulse;
		@(posedge clk_sys);
		capture_port_en <= 1'b1;
		for (int s = 0; s < 16; s++) begin
			@(posedge clk_sys);
			capture_sel <= 4'(s);
			repeat (2) @(posedge clk_sys);
			#1 chk("capture", capture_data, f28(s < 7 ? wave_in[s] :
				phase_power[(s - 7) / 3][(s - 7) % 3]));
		end
		i_host.wr(`MRO_ADDR_COMPENSATION_MODE_CONTROL, 32'h0000_0071);
		for (int c = 0; c < 6; c++) begin
			pp = '0;
			for (int t = 0; t < 5; t++)
				if (c == t || c == 5)
					pp[t][0] = 24'h7f_ffff;
			@(posedge clk_sys);
			phase_power <= pp;
			i_host.wr(`MRO_ADDR_CFMODE, {23'h0, 3'(c), 3'(c), 3'(c)});
			watch;
			chk("pulse one", 32'(lo1), 32'(c < 5));
			chk("pulse two", 32'(lo2), 32'h0);
			chk("pulse three", 32'(lo3), 32'h0);
		end
		i_host.wr(`MRO_ADDR_COMPENSATION_MODE_CONTROL, 32'h0000_0070);
		i_host.wr(`MRO_ADDR_CFMODE, 32'h0);
		// Releasing the capture port lets the third output reach its pin.
		@(posedge clk_sys);
		capture_port_en <= 1'b0;
		watch;
		chk("empty field", 32'(lo1), 32'h0);
		chk("pulse three free", 32'(lo3), 32'h1);
		$display("t_pulse done");
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		arst_n = 1'b0;
		crossing_in = 1'b1;
		capture_port_en = 1'b0;
		capture_sel = 4'h0;
		rms_total = {6{24'h10_0000}};
		rms_fund = {6{24'h10_0000}};
		rms_total[0] = 24'h50_0000;
		rms_fund[0] = 24'h40_0000;
		rms_total[1] = 24'h50_0000;
		for (int i = 0; i < 12; i++)
			wave_in[i] = i % 2 ? 24'h01_2340 + 24'(i) : 24'hf0_0000 + 24'(i);
		for (int t = 0; t < 5; t++)
			for (int p = 0; p < 3; p++)
				phase_power[t][p] = (t + p) % 2 ? 24'hc0_0010 + 24'(t * 4 + p) :
					24'h00_0200 + 24'(t * 4 + p);
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_config;
		t_reset;
		t_ready;
		t_pulse;
		wrap_up;
	end
endmodule
bind mro_output_stage mro_output_stage_chk i_mro_output_stage_chk (
	.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .crossing_in(crossing_in),
	.capture_port_en(capture_port_en), .capture_data(capture_data),
	.irq_n(irq_n), .crossing_ready_pin(crossing_ready_pin),
	.pulse_out_3_n(pulse_out_3_n));
`default_nettype wire
